// ==== core/adccr_buf2.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module adccr_buf2
    import adccr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input adccr_word_t in_word,
    output logic out_valid,
    input wire logic out_ready,
    output adccr_word_t out_word
);
    adccr_word_t mem_q [2];
    adccr_word_t mem_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic rd_q, rd_d, wr_q, wr_d;
    logic push, pop;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_word = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_d = mem_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        wr_d = wr_q;
        if (push) begin
            mem_d[wr_q] = in_word;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            cnt_q <= 2'h0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
        end
    end

    chk_buf_no_overfill: assert property (@(posedge clk) disable iff (rst)
        cnt_q <= 2'h2) else $error("Buffer count above two.");

endmodule : adccr_buf2

// ==== core/adccr_ctrl.sv ====
// Conversion and read control of a 16-bit sampling converter behind its parallel port.
// Assumes pin inputs are asynchronous to clk and that the converter core delivers
// a two's complement result word on sar_word with sar_valid, stalled by sar_ready.
//
// Operation
// - Start on convert-start falling edge while selected.
// - Deselected device ignores start and read.
// - Busy low during conversion, high otherwise.
// - Result on data outputs before busy rises.
// - Drivers enabled only with read and select low.
// - Read before select waits for select.
// - Sixteen-bit word, top output carries MSB.
// - Conversion done within 1.8 us.
// - Acquisition plus conversion within 2 us.
// - Shutdown low: nap if selected, else sleep.
// - Start edges ignored during a conversion.
// - Results are two's complement binary.
// - Previous result held until new completes.
// - Ready again within 200 ns after nap.
`timescale 1ns/1ps
module adccr_ctrl
    import adccr_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic convert_start_n,
    input wire logic chip_sel_n,
    input wire logic read_n,
    input wire logic power_down_n,
    input adccr_word_t sar_word,
    input wire logic sar_valid,
    output logic sar_ready,
    output logic sar_start,
    output logic busy_n,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic nap,
    output logic sleep
);
    // Three-stage synchronisers; a change counts when stages two and three agree.
    logic [2:0] cs_s_q, rd_s_q, cv_s_q, pd_s_q;
    logic cs_l, rd_l, cv_l, pd_l;
    logic cs_q, rd_q, cv_q, pd_q;
    logic cs_d, rd_d, cv_d, pd_d;

    always_comb begin
        cs_d = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_q;
        rd_d = (rd_s_q[1] == rd_s_q[2]) ? rd_s_q[2] : rd_q;
        cv_d = (cv_s_q[1] == cv_s_q[2]) ? cv_s_q[2] : cv_q;
        pd_d = (pd_s_q[1] == pd_s_q[2]) ? pd_s_q[2] : pd_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_s_q <= 3'h7;
            rd_s_q <= 3'h7;
            cv_s_q <= 3'h7;
            pd_s_q <= 3'h7;
            cs_q <= 1'b1;
            rd_q <= 1'b1;
            cv_q <= 1'b1;
            pd_q <= 1'b1;
        end else begin
            cs_s_q <= {cs_s_q[1:0], chip_sel_n};
            rd_s_q <= {rd_s_q[1:0], read_n};
            cv_s_q <= {cv_s_q[1:0], convert_start_n};
            pd_s_q <= {pd_s_q[1:0], power_down_n};
            cs_q <= cs_d;
            rd_q <= rd_d;
            cv_q <= cv_d;
            pd_q <= pd_d;
        end
    end

    assign cs_l = cs_q;
    assign rd_l = rd_q;
    assign cv_l = cv_q;
    assign pd_l = pd_q;

    // Previous start level for falling-edge detection.
    logic cv_prev_q;
    logic start_edge;
    assign start_edge = cv_prev_q && !cv_l && !cs_l;

    // Result path: the core's word passes a two-entry buffer before the output latch.
    adccr_word_t buf_word;
    logic buf_valid, buf_ready;

    adccr_buf2 u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(sar_valid),
        .in_ready(sar_ready),
        .in_word(sar_word),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_word(buf_word)
    );

    adccr_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] thru_q, thru_d;
    logic [DATA_W-1:0] res_q, res_d;
    logic busy_n_q, busy_n_d;
    logic start_q, start_d;
    logic was_nap_q, was_nap_d;
    adccr_pmode_t pm;

    always_comb begin
        if (pd_l) begin
            pm = PM_ACTIVE;
        end else if (!cs_l) begin
            pm = PM_NAP;
        end else begin
            pm = PM_SLEEP;
        end
    end

    assign buf_ready = (st_q == ST_CONV);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        thru_d = (thru_q != '0) ? thru_q - 5'(1) : thru_q;
        res_d = res_q;
        busy_n_d = busy_n_q;
        start_d = 1'b0;
        was_nap_d = was_nap_q;
        unique case (st_q)
            ST_IDLE: begin
                if (pm != PM_ACTIVE) begin
                    was_nap_d = (pm == PM_NAP);
                    st_d = ST_WAKE;
                    cnt_d = CNT_W'(NAP_WAKE_CYC);
                end else if (start_edge) begin
                    st_d = ST_CONV;
                    busy_n_d = 1'b0;
                    start_d = 1'b1;
                    // The limit counts from the pin edge, so the pin latency is taken off.
                    cnt_d = CNT_W'(CONV_CYCLES - LEAD_CYC - 1 - START_LAT_CYC);
                    thru_d = CNT_W'(THRU_CYC - START_LAT_CYC);
                end
            end
            ST_CONV: begin
                // Start edges are not looked at here, so a conversion cannot restart.
                if (buf_valid) begin
                    res_d = buf_word.data;
                    st_d = ST_LOAD;
                end else if (cnt_q != '0) begin
                    cnt_d = cnt_q - 5'(1);
                end else begin
                    // No word arrived in time: end the conversion and keep the old result.
                    st_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                busy_n_d = 1'b1;
                st_d = ST_IDLE;
            end
            ST_WAKE: begin
                if (pm != PM_ACTIVE) begin
                    was_nap_d = (pm == PM_NAP);
                    cnt_d = CNT_W'(NAP_WAKE_CYC);
                end else if (cnt_q > CNT_W'(1)) begin
                    cnt_d = cnt_q - 5'(1);
                end else begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            thru_q <= '0;
            res_q <= RESULT_RST;
            busy_n_q <= 1'b1;
            start_q <= 1'b0;
            was_nap_q <= 1'b0;
            cv_prev_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            thru_q <= thru_d;
            res_q <= res_d;
            busy_n_q <= busy_n_d;
            start_q <= start_d;
            was_nap_q <= was_nap_d;
            cv_prev_q <= cv_l;
        end
    end

    assign busy_n = busy_n_q;
    assign sar_start = start_q;
    assign data_out = res_q;
    assign data_oe_n = !(!rd_l && !cs_l);
    assign nap = (pm == PM_NAP);
    assign sleep = (pm == PM_SLEEP);

    chk_busy_in_conv: assert property (@(posedge clk) disable iff (rst)
        (st_q == ST_CONV) |-> !busy_n) else $error("Busy high during conversion.");
    chk_start_selected: assert property (@(posedge clk) disable iff (rst)
        $fell(busy_n) |-> $past(!cs_l) && $past(pd_l)) else $error("Start while deselected.");
    chk_start_edge: assert property (@(posedge clk) disable iff (rst)
        (st_q == ST_IDLE && start_edge && pd_l) |=> !busy_n) else $error("Start edge lost.");
    chk_conv_bound: assert property (@(posedge clk) disable iff (rst)
        $fell(busy_n) |-> ##[1:13] busy_n) else $error("Conversion too long.");
    chk_data_lead: assert property (@(posedge clk) disable iff (rst)
        $rose(busy_n) |-> $stable(data_out)) else $error("Data changed at busy rise.");
    chk_hold_prev: assert property (@(posedge clk) disable iff (rst)
        (!busy_n && st_q == ST_CONV && $past(st_q) == ST_CONV) |-> $stable(data_out))
        else $error("Result changed mid-conversion.");
    chk_oe_gate: assert property (@(posedge clk) disable iff (rst)
        !data_oe_n |-> (!rd_l && !cs_l)) else $error("Drivers on while not read.");
    chk_no_restart: assert property (@(posedge clk) disable iff (rst)
        (!busy_n && $past(!busy_n)) |-> !sar_start) else $error("Conversion restarted.");
    chk_no_start_down: assert property (@(posedge clk) disable iff (rst)
        !pd_l |=> !sar_start) else $error("Start while shut down.");
    chk_nap_wake: assert property (@(posedge clk) disable iff (rst)
        ($rose(pd_l) && was_nap_q) |-> ##[0:3] (st_q == ST_IDLE)) else $error("Nap wake slow.");
    chk_throughput: assert property (@(posedge clk) disable iff (rst)
        $fell(busy_n) |-> ##[1:15] busy_n) else $error("Throughput exceeded.");
    chk_thru_window: assert property (@(posedge clk) disable iff (rst)
        $rose(busy_n) |-> (thru_q != '0)) else $error("Busy rose after window.");

endmodule : adccr_ctrl

// ==== pkg/adccr_pkg.sv ====
// Package for the converter control block: timing counts, modes and carried words.
// Assumes a 10 MHz system clock; all counts are in cycles of that clock.
package adccr_pkg;

    localparam int CLK_NS = 100;
    localparam int DATA_W = 16;
    // Conversion time limit, longest, in ns; count rounds down.
    localparam int CONV_MAX_NS = 1800;
    localparam int CONV_CYC = CONV_MAX_NS / CLK_NS;
    // Throughput time, longest, in ns; acquisition fills the rest.
    localparam int THRU_MAX_NS = 2000;
    localparam int THRU_CYC = THRU_MAX_NS / CLK_NS;
    // Nap wake time, longest, in ns; count rounds down, at least one.
    localparam int NAP_WAKE_NS = 200;
    localparam int NAP_WAKE_CYC = (NAP_WAKE_NS / CLK_NS) < 1 ? 1 : NAP_WAKE_NS / CLK_NS;
    // Result lead before busy rises, least, in ns; count rounds up.
    localparam int LEAD_NS = 32;
    localparam int LEAD_CYC = (LEAD_NS + CLK_NS - 1) / CLK_NS;
    // Cycles from a start pin edge to the first conversion cycle: three
    // synchroniser stages, the settled level and the state register.
    localparam int START_LAT_CYC = 5;
    localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;
    localparam int CNT_W = 5;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_WAKE = 4'b1000
    } adccr_state_t;

    typedef enum logic [1:0] {
        PM_ACTIVE = 2'h0,
        PM_NAP = 2'h1,
        PM_SLEEP = 2'h2
    } adccr_pmode_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
    } adccr_word_t;

endpackage : adccr_pkg

// ==== verif/adccr_core_model.sv ====
// Behavioural model of the converter core behind the control block.
// Assumes sar_start is a one-cycle pulse; answers after a delay set by the bench.
`timescale 1ns/1ps
module adccr_core_model
    import adccr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sar_start,
    input wire logic sar_ready,
    input wire logic [7:0] dly,
    input wire logic [DATA_W-1:0] next_data,
    output logic sar_valid,
    output adccr_word_t sar_word
);
    logic [7:0] cnt_q;

    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            sar_valid <= 1'b0;
            sar_word.data <= 16'h5a5a;
        end else begin
            if (sar_start) begin
                cnt_q <= dly;
            end else if (cnt_q > 8'h01) begin
                cnt_q <= cnt_q - 8'h01;
            end else if (cnt_q == 8'h01) begin
                cnt_q <= 8'h00;
                sar_valid <= 1'b1;
                sar_word.data <= next_data;
            end
            // A taken word is released and the bus shows its inverse, not the old value.
            if (sar_valid && sar_ready) begin
                sar_valid <= 1'b0;
                sar_word.data <= ~sar_word.data;
            end
        end
    end
endmodule : adccr_core_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the converter control block and a core model.
// Assumes the design defaults; the host pins are driven 10 ns after each edge.
`timescale 1ns/1ps
module tb_top;
    import adccr_pkg::*;
    logic clk, rst, convert_start_n, chip_sel_n, read_n, power_down_n;
    logic sar_ready, sar_start, sar_valid, busy_n, data_oe_n, nap, sleep;
    logic [7:0] dly;
    logic [DATA_W-1:0] next_data, data_out, last_w;
    adccr_word_t sar_word;
    int mismatches, cmp_count;

    adccr_ctrl u_adccr_ctrl (.clk(clk), .rst(rst), .convert_start_n(convert_start_n),
        .chip_sel_n(chip_sel_n), .read_n(read_n), .power_down_n(power_down_n),
        .sar_word(sar_word), .sar_valid(sar_valid), .sar_ready(sar_ready),
        .sar_start(sar_start), .busy_n(busy_n), .data_out(data_out),
        .data_oe_n(data_oe_n), .nap(nap), .sleep(sleep));
    adccr_core_model u_adccr_core_model (.clk(clk), .rst(rst), .sar_start(sar_start),
        .sar_ready(sar_ready), .dly(dly), .next_data(next_data), .sar_valid(sar_valid),
        .sar_word(sar_word));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : step

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t bit got %b want %b", $time, got, exp);
        end
    endtask : chk1

    task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t word got %h want %h", $time, got, exp);
        end
    endtask : chk16

    task automatic wait_busy(input logic v, output int n);
        n = 0;
        while (busy_n !== v && n < 20) begin
            step(1);
            n++;
        end
        chk1(busy_n, v);
    endtask : wait_busy

    task automatic busy_len(inout int n);
        while (busy_n === 1'b0 && n < 40) begin
            step(1);
            n++;
        end
        chk1(n <= CONV_CYC, 1'b1);
    endtask : busy_len

    task automatic t_conv(input logic [DATA_W-1:0] w);
        int n;
        next_data = w;
        convert_start_n = 1'b0;
        wait_busy(1'b0, n);
        chk16(data_out, last_w);
        busy_len(n);
        chk16(data_out, w);
        convert_start_n = 1'b1;
        last_w = w;
        step(20);
    endtask : t_conv

    task automatic t_desel;
        chip_sel_n = 1'b1;
        step(5);
        read_n = 1'b0;
        convert_start_n = 1'b0;
        step(10);
        chk1(busy_n, 1'b1);
        chk1(data_oe_n, 1'b1);
        convert_start_n = 1'b1;
        read_n = 1'b1;
        step(5);
        chip_sel_n = 1'b0;
        step(5);
    endtask : t_desel

    task automatic t_read;
        chip_sel_n = 1'b1;
        read_n = 1'b0;
        step(8);
        chk1(data_oe_n, 1'b1);
        chip_sel_n = 1'b0;
        step(5);
        chk1(data_oe_n, 1'b0);
        chk16(data_out, last_w);
        read_n = 1'b1;
        step(5);
        chk1(data_oe_n, 1'b1);
    endtask : t_read

    task automatic t_twice;
        int k;
        int n;
        dly = 8'd8;
        next_data = 16'h1234;
        convert_start_n = 1'b0;
        wait_busy(1'b0, n);
        convert_start_n = 1'b1;
        step(4);
        convert_start_n = 1'b0;
        step(4);
        wait_busy(1'b1, n);
        chk16(data_out, 16'h1234);
        last_w = 16'h1234;
        convert_start_n = 1'b1;
        k = 0;
        repeat (25) begin
            step(1);
            if (busy_n !== 1'b1) k++;
        end
        chk1(k == 0, 1'b1);
        dly = 8'd3;
    endtask : t_twice

    task automatic t_pd;
        power_down_n = 1'b0;
        step(6);
        chk1(nap, 1'b1);
        chk1(sleep, 1'b0);
        chip_sel_n = 1'b1;
        step(6);
        chk1(sleep, 1'b1);
        chk1(nap, 1'b0);
        chip_sel_n = 1'b0;
        step(6);
        convert_start_n = 1'b0;
        step(8);
        chk1(busy_n, 1'b1);
        convert_start_n = 1'b1;
        step(4);
        power_down_n = 1'b1;
        step(5);
        t_conv(16'h0f0f);
    endtask : t_pd

    task automatic t_slow;
        int n;
        dly = 8'd40;
        next_data = 16'hc3c3;
        convert_start_n = 1'b0;
        wait_busy(1'b0, n);
        busy_len(n);
        chk1(busy_n, 1'b1);
        chk16(data_out, last_w);
        convert_start_n = 1'b1;
        step(50);
    endtask : t_slow

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #2000000;
        mismatches++;
        finish_test();
    end

    initial begin
        mismatches = 0;
        cmp_count = 0;
        rst = 1'b1;
        convert_start_n = 1'b1;
        chip_sel_n = 1'b0;
        read_n = 1'b1;
        power_down_n = 1'b1;
        dly = 8'd3;
        next_data = 16'h0000;
        last_w = RESULT_RST;
        repeat (16) @(posedge clk);
        #10;
        rst = 1'b0;
        step(4);
        chk1(busy_n, 1'b1);
        t_conv(16'h8001);
        t_conv(16'h7ffe);
        t_desel();
        t_read();
        t_twice();
        t_pd();
        t_slow();
        finish_test();
    end
endmodule : tb_top
